// File: guard_cfg.svh
// Constants for the serial EEPROM write guard
`ifndef GUARD_CFG_SVH
`define GUARD_CFG_SVH
`define ADDR_W         13
`define OP_W           8
`define OP_LATCH_SET   8'h06
`define OP_LATCH_CLEAR 8'h04
`define SEG_QUARTER_LO 13'h1800
`define SEG_HALF_LO    13'h1000
`define SEG_TOP        13'h1fff
`define BP_NONE        2'h0
`define BP_QUARTER     2'h1
`define BP_HALF        2'h2
`define BP_ALL         2'h3
`define ST_HPE_BIT     7
`define ST_BP_HI       3
`define ST_BP_LO       2
`define ST_LATCH_BIT   1
`define ST_BUSY_BIT    0
`define RST_HPE        1'b0
`define RST_BP         2'h0
`endif

// File: guard_pkg.sv
// Types shared by the write guard modules
`include "guard_cfg.svh"
package guard_pkg;
	typedef enum logic [0:0] {
		ST_STANDBY = 1'b0,
		ST_ACTIVE  = 1'b1
	} link_state_e;
	typedef enum logic {
		REQ_ARRAY  = 1'b0,
		REQ_STATUS = 1'b1
	} req_kind_e;
	typedef struct packed {
		req_kind_e           kind;
		logic [`ADDR_W-1:0]  addr;
		logic [7:0]          sdata;
	} wr_req_s;
endpackage

// File: opcode_capture.sv
// Serial clock side: captures the first byte of each frame
`timescale 1ns/10ps
`include "guard_cfg.svh"
module opcode_capture (
	// Link pins
	input  wire logic             sck_in,
	input  wire logic             cs_b_in,
	input  wire logic             si_in,
	// Frame results, cleared while chip select is high
	output logic [`OP_W-1:0]      opcode_out,
	output logic                  op_valid_out,
	output logic                  over_out
);
	logic [3:0]       bit_count;
	logic [3:0]       next_bit_count;
	logic [`OP_W-1:0] shift;
	logic [`OP_W-1:0] next_shift;
	logic [`OP_W-1:0] next_opcode;
	logic             next_op_valid;
	logic             next_over;

	// Bit counter saturates at eight; later bits only flag an overrun
	always_comb begin
		next_shift     = {shift[`OP_W-2:0], si_in};
		next_bit_count = bit_count;
		next_opcode    = opcode_out;
		next_op_valid  = op_valid_out;
		next_over      = over_out;
		if (bit_count == 4'h8) begin
			next_over = 1'b1;
		end else begin
			next_bit_count = bit_count + 4'h1;
		end
		if (bit_count == 4'h7) begin
			next_opcode   = next_shift;
			next_op_valid = 1'b1;
		end
	end

	// Chip select high clears the frame; the serial clock may stop
	always_ff @(posedge sck_in or posedge cs_b_in) begin
		if (cs_b_in) begin
			bit_count    <= 4'h0;
			shift        <= 8'h00;
			opcode_out   <= 8'h00;
			op_valid_out <= 1'b0;
			over_out     <= 1'b0;
		end else begin
			bit_count    <= next_bit_count;
			shift        <= next_shift;
			opcode_out   <= next_opcode;
			op_valid_out <= next_op_valid;
			over_out     <= next_over;
		end
	end
endmodule // opcode_capture

// File: eeprom_write_guard.sv
// Write guard and power-on state of a serial EEPROM slave
`timescale 1ns/10ps
`include "guard_cfg.svh"
module eeprom_write_guard #(
	parameter int ADDR_W = `ADDR_W
) (
	// Clock and reset
	input  wire logic              CLK_IN,
	input  wire logic              RST_B_IN,
	// Link pins
	input  wire logic              SCK_IN,
	input  wire logic              CS_B_IN,
	input  wire logic              SI_IN,
	input  wire logic              WP_B_IN,
	output logic                   SO_OUT,
	output logic                   SO_OE_B_OUT,
	// Sequencer side
	input  wire logic              WR_REQ_VALID_IN,
	input  wire guard_pkg::wr_req_s WR_REQ_IN,
	input  wire logic              WRITE_DONE_IN,
	input  wire logic              BUSY_IN,
	input  wire logic              SO_DATA_IN,
	input  wire logic              SO_EN_IN,
	output logic                   GRANT_OUT,
	output logic                   REJECT_OUT,
	output logic                   ACTIVE_OUT,
	output logic [7:0]             STATUS_OUT
);
	// Elaboration check
	if (ADDR_W != 13) begin : g_addr_check
		$error("eeprom_write_guard serves a 13-bit array address only");
	end

	// Protected range decode of the block guard bits
	function automatic logic is_guarded(input logic [1:0] bp, input logic [ADDR_W-1:0] a);
		unique case (bp)
			`BP_NONE:    is_guarded = 1'b0;
			`BP_QUARTER: is_guarded = (a >= `SEG_QUARTER_LO) && (a <= `SEG_TOP);
			`BP_HALF:    is_guarded = (a >= `SEG_HALF_LO) && (a <= `SEG_TOP);
			`BP_ALL:     is_guarded = 1'b1;
		endcase
	endfunction

	logic [`OP_W-1:0]      cap_opcode;
	logic                  cap_valid;
	logic                  cap_over;
	logic                  cs_meta;
	logic                  cs_sync;
	logic                  cs_prev;
	logic                  opv_meta;
	logic                  opv_sync;
	logic                  ovr_meta;
	logic                  ovr_sync;
	logic                  wp_meta;
	logic                  wp_sync;
	guard_pkg::link_state_e state;
	guard_pkg::link_state_e next_state;
	logic [`OP_W-1:0]      frame_op;
	logic [`OP_W-1:0]      next_frame_op;
	logic                  frame_opv;
	logic                  next_frame_opv;
	logic                  frame_ovr;
	logic                  next_frame_ovr;
	logic                  latch;
	logic                  next_latch;
	logic                  hpe;
	logic                  next_hpe;
	logic [1:0]            bp;
	logic [1:0]            next_bp;
	logic                  next_grant;
	logic                  next_reject;
	logic                  next_so;
	logic                  next_so_oe_b;
	logic [7:0]            next_status;
	logic                  cs_fall;
	logic                  cs_rise;
	logic                  set_evt;
	logic                  clr_evt;
	logic                  allow;

	// Serial clock domain front end
	opcode_capture u_capture (
		.sck_in       (SCK_IN),
		.cs_b_in      (CS_B_IN),
		.si_in        (SI_IN),
		.opcode_out   (cap_opcode),
		.op_valid_out (cap_valid),
		.over_out     (cap_over)
	);

	// Edges and decisions
	assign cs_fall = cs_prev & ~cs_sync;
	assign cs_rise = ~cs_prev & cs_sync;
	assign set_evt = (state == guard_pkg::ST_ACTIVE) && cs_rise && frame_opv && !frame_ovr
		&& (frame_op == `OP_LATCH_SET);
	assign clr_evt = (state == guard_pkg::ST_ACTIVE) && cs_rise && frame_opv && !frame_ovr
		&& (frame_op == `OP_LATCH_CLEAR);
	always_comb begin
		if (!latch || BUSY_IN) begin
			allow = 1'b0;
		end else if (WR_REQ_IN.kind == guard_pkg::REQ_STATUS) begin
			allow = !hpe || wp_sync;
		end else begin
			allow = !is_guarded(bp, WR_REQ_IN.addr);
		end
	end

	// Next values of link state, latch, status bits and outputs
	always_comb begin
		next_state     = state;
		next_frame_op  = frame_op;
		next_frame_opv = frame_opv;
		next_frame_ovr = frame_ovr;
		next_latch     = latch;
		next_hpe       = hpe;
		next_bp        = bp;
		unique case (state)
			guard_pkg::ST_STANDBY: begin
				if (cs_fall) begin
					next_state     = guard_pkg::ST_ACTIVE;
					next_frame_opv = 1'b0;
					next_frame_ovr = 1'b0;
				end
			end
			guard_pkg::ST_ACTIVE: begin
				if (opv_sync && !frame_opv) begin
					next_frame_op  = cap_opcode; // Stable while valid level is high
					next_frame_opv = 1'b1;
				end
				if (ovr_sync) begin
					next_frame_ovr = 1'b1;
				end
				if (cs_rise) begin
					next_state = guard_pkg::ST_STANDBY;
				end
			end
		endcase
		if (WRITE_DONE_IN || clr_evt) begin
			next_latch = 1'b0;
		end
		if (set_evt) begin
			next_latch = 1'b1; // Set wins over clear
		end
		if (WR_REQ_VALID_IN && allow && WR_REQ_IN.kind == guard_pkg::REQ_STATUS) begin
			next_hpe = WR_REQ_IN.sdata[`ST_HPE_BIT];
			next_bp  = WR_REQ_IN.sdata[`ST_BP_HI:`ST_BP_LO];
		end
		next_grant   = WR_REQ_VALID_IN && allow;
		next_reject  = WR_REQ_VALID_IN && !allow;
		next_so      = SO_DATA_IN;
		next_so_oe_b = !((state == guard_pkg::ST_ACTIVE) && SO_EN_IN);
		next_status  = 8'h00;
		next_status[`ST_HPE_BIT]            = hpe;
		next_status[`ST_BP_HI:`ST_BP_LO]    = bp;
		next_status[`ST_LATCH_BIT]          = latch;
		next_status[`ST_BUSY_BIT]           = BUSY_IN;
	end

	// Registers; chip select synchroniser resets high
	always_ff @(posedge CLK_IN) begin
		if (!RST_B_IN) begin
			cs_meta     <= 1'b1;
			cs_sync     <= 1'b1;
			cs_prev     <= 1'b1;
			opv_meta    <= 1'b0;
			opv_sync    <= 1'b0;
			ovr_meta    <= 1'b0;
			ovr_sync    <= 1'b0;
			wp_meta     <= 1'b1;
			wp_sync     <= 1'b1;
			state       <= guard_pkg::ST_STANDBY;
			frame_op    <= 8'h00;
			frame_opv   <= 1'b0;
			frame_ovr   <= 1'b0;
			latch       <= 1'b0;
			hpe         <= `RST_HPE;
			bp          <= `RST_BP;
			GRANT_OUT   <= 1'b0;
			REJECT_OUT  <= 1'b0;
			SO_OUT      <= 1'b0;
			SO_OE_B_OUT <= 1'b1;
			STATUS_OUT  <= 8'h00;
		end else begin
			cs_meta     <= CS_B_IN;
			cs_sync     <= cs_meta;
			cs_prev     <= cs_sync;
			opv_meta    <= cap_valid;
			opv_sync    <= opv_meta;
			ovr_meta    <= cap_over;
			ovr_sync    <= ovr_meta;
			wp_meta     <= WP_B_IN;
			wp_sync     <= wp_meta;
			state       <= next_state;
			frame_op    <= next_frame_op;
			frame_opv   <= next_frame_opv;
			frame_ovr   <= next_frame_ovr;
			latch       <= next_latch;
			hpe         <= next_hpe;
			bp          <= next_bp;
			GRANT_OUT   <= next_grant;
			REJECT_OUT  <= next_reject;
			SO_OUT      <= next_so;
			SO_OE_B_OUT <= next_so_oe_b;
			STATUS_OUT  <= next_status;
		end
	end

	assign ACTIVE_OUT = (state == guard_pkg::ST_ACTIVE);

	// Checks
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!RST_B_IN);

	sequence quiet_standby_seq;
		(state == guard_pkg::ST_STANDBY) && !cs_fall;
	endsequence
	sequence req_refused_seq;
		WR_REQ_VALID_IN && !allow;
	endsequence

	reset_standby_a: assert property (
		$past(RST_B_IN) == 1'b0 |-> state == guard_pkg::ST_STANDBY && !latch)
		else $error("not in standby with latch clear after reset");
	so_release_a: assert property (
		(state == guard_pkg::ST_STANDBY) |=> SO_OE_B_OUT)
		else $error("data output driven in standby");
	enter_active_a: assert property (
		quiet_standby_seq |=> state == guard_pkg::ST_STANDBY)
		else $error("active without chip select fall");
	no_latch_a: assert property (
		WR_REQ_VALID_IN && !latch |=> REJECT_OUT && !GRANT_OUT)
		else $error("write granted with latch clear");
	status_open_a: assert property (
		WR_REQ_VALID_IN && latch && !BUSY_IN && WR_REQ_IN.kind == guard_pkg::REQ_STATUS
		&& (!hpe || wp_sync) |=> GRANT_OUT)
		else $error("open status write refused");
	status_locked_a: assert property (
		WR_REQ_VALID_IN && hpe && !wp_sync && WR_REQ_IN.kind == guard_pkg::REQ_STATUS
		|=> REJECT_OUT)
		else $error("status write passed hardware protection");
	block_lock_a: assert property (
		WR_REQ_VALID_IN && WR_REQ_IN.kind == guard_pkg::REQ_ARRAY && bp == `BP_QUARTER
		&& WR_REQ_IN.addr >= `SEG_QUARTER_LO |=> REJECT_OUT)
		else $error("write to guarded block granted");
	// A set command one cycle after completion may legally reopen the latch
	latch_done_a: assert property (
		WRITE_DONE_IN && !set_evt |=> !latch ##1 (!latch || $past(set_evt)))
		else $error("latch kept after write completion");
	cmd_latch_a: assert property (set_evt |=> latch) else $error("latch set ignored");
	reject_quiet_a: assert property (
		req_refused_seq |=> $stable(hpe) && $stable(bp) && !GRANT_OUT)
		else $error("refused write changed status");
endmodule // eeprom_write_guard

// File: spi_host_model.sv
// Serial link host model driving the guard's link pins
`timescale 1ns/10ps
module spi_host_model (
	// Link pins
	output logic sck_out,
	output logic cs_b_out,
	output logic si_out
);
	// Idle link: deselected, clock stands still
	initial begin
		sck_out = 1'b0;
		cs_b_out = 1'b1;
		si_out = 1'b0;
	end
	// One frame, MSB first, opened by a falling select
	task automatic frame(input logic [7:0] op, input int n);
		#7 cs_b_out = 1'b0;
		#200;
		for (int i = 0; i < n; i++) begin
			si_out = op[7 - i];
			#6 sck_out = 1'b1;
			#6 sck_out = 1'b0;
		end
		#200 cs_b_out = 1'b1;
		si_out = ~si_out; // Released line shows no stale bit
		#400;
	endtask
endmodule // spi_host_model

// File: eeprom_write_guard_tb.sv
// Self-checking bench for the EEPROM write guard
`timescale 1ns/10ps
`include "guard_cfg.svh"
module eeprom_write_guard_tb;
	typedef struct packed {
		logic        hpe;
		logic [1:0]  bp;
		logic        wp;
		logic        lat;
		logic        kind;
		logic [12:0] addr;
		logic        ok;
	} row_s;
	logic clk, rst_b, wp_b, valid, done, busy, so_d, so_en;
	logic so, so_oe_b, grant, reject, active;
	logic [7:0] status;
	guard_pkg::wr_req_s wr;
	wire sck, cs_b, si;
	int n_errors = 0;
	int checks = 0;
	// Decision table
	row_s rows [11] = '{
		'{1'h0, 2'h0, 1'h1, 1'h0, 1'h0, 13'h0000, 1'h0},
		'{1'h1, 2'h0, 1'h1, 1'h0, 1'h1, 13'h0000, 1'h0},
		'{1'h0, 2'h0, 1'h0, 1'h1, 1'h1, 13'h0000, 1'h1},
		'{1'h1, 2'h0, 1'h0, 1'h1, 1'h1, 13'h0000, 1'h0},
		'{1'h1, 2'h0, 1'h0, 1'h1, 1'h0, 13'h0123, 1'h1},
		'{1'h1, 2'h0, 1'h1, 1'h1, 1'h1, 13'h0000, 1'h1},
		'{1'h0, 2'h3, 1'h1, 1'h1, 1'h0, 13'h0000, 1'h0},
		'{1'h0, 2'h1, 1'h1, 1'h1, 1'h0, 13'h1800, 1'h0},
		'{1'h0, 2'h1, 1'h1, 1'h1, 1'h0, 13'h17ff, 1'h1},
		'{1'h0, 2'h2, 1'h1, 1'h1, 1'h0, 13'h1000, 1'h0},
		'{1'h0, 2'h2, 1'h1, 1'h1, 1'h0, 13'h0fff, 1'h1}};

	spi_host_model host (.sck_out(sck), .cs_b_out(cs_b), .si_out(si));

	eeprom_write_guard u_dut (.CLK_IN(clk), .RST_B_IN(rst_b), .SCK_IN(sck), .CS_B_IN(cs_b),
		.SI_IN(si), .WP_B_IN(wp_b), .SO_OUT(so), .SO_OE_B_OUT(so_oe_b),
		.WR_REQ_VALID_IN(valid), .WR_REQ_IN(wr), .WRITE_DONE_IN(done), .BUSY_IN(busy),
		.SO_DATA_IN(so_d), .SO_EN_IN(so_en), .GRANT_OUT(grant), .REJECT_OUT(reject),
		.ACTIVE_OUT(active), .STATUS_OUT(status));

	// Bit and byte compares
	task automatic chk1(input string n, input logic e, input logic s);
		checks++;
		if (s !== e) begin
			n_errors++;
			$display("BAD %s expected %b seen %b", n, e, s);
		end
	endtask
	task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] s);
		checks++;
		if (s !== e) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask
	// Verdict and end of run
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// One write request; answer looked for in a bounded window
	task automatic req(input logic k, input logic [12:0] a, input logic [7:0] d,
		output logic g, output logic j);
		@(posedge clk);
		#2 valid = 1'b1;
		wr = '{kind: guard_pkg::req_kind_e'(k), addr: a, sdata: d};
		@(posedge clk);
		#2 valid = 1'b0;
		g = 1'b0;
		j = 1'b0;
		repeat (2) begin
			if (grant === 1'b1) g = 1'b1;
			if (reject === 1'b1) j = 1'b1;
			@(posedge clk);
			#2;
		end
	endtask
	// Programming cycle completion pulse
	task automatic pulse_done();
		@(posedge clk);
		#2 done = 1'b1;
		@(posedge clk);
		#2 done = 1'b0;
		repeat (2) @(posedge clk);
		#2;
	endtask
	// Set up protection, then one decision
	task automatic run_row(input row_s r);
		logic g, j;
		host.frame(`OP_LATCH_SET, 8);
		@(posedge clk);
		#2 wp_b = 1'b1;
		repeat (3) @(posedge clk);
		req(1'b1, 13'h0000, {r.hpe, 3'h0, r.bp, 2'h0}, g, j);
		pulse_done();
		if (r.lat) host.frame(`OP_LATCH_SET, 8);
		@(posedge clk);
		#2 wp_b = r.wp;
		repeat (3) @(posedge clk);
		#2;
		chk8("status", {r.hpe, 3'h0, r.bp, r.lat, 1'b0}, status);
		req(r.kind, r.addr, {r.hpe, 3'h0, r.bp, 2'h0}, g, j);
		chk1("grant", r.ok, g);
		chk1("reject", !r.ok, j);
		pulse_done();
	endtask

	// Clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Hang guard
	initial begin
		#3000000;
		n_errors++;
		$display("BAD watchdog expected finish seen hang");
		end_of_test();
	end
	// Main sequence
	initial begin
		logic g, j;
		rst_b = 1'b0;
		wp_b = 1'b1;
		valid = 1'b0;
		wr = '0;
		done = 1'b0;
		busy = 1'b0;
		so_d = 1'b1;
		so_en = 1'b1;
		repeat (3) @(posedge clk);
		#2 rst_b = 1'b1;
		@(posedge clk);
		#2;
		chk1("active", 1'b0, active);
		chk1("so_oe_b", 1'b1, so_oe_b);
		chk8("status", 8'h00, status);
		$display("reset test done");
		foreach (rows[i]) run_row(rows[i]);
		$display("table test done");
		// Inside a frame: active and driving
		fork
			host.frame(`OP_LATCH_SET, 8);
			begin
				repeat (8) @(posedge clk);
				#2;
				chk1("active", 1'b1, active);
				chk1("so_oe_b", 1'b0, so_oe_b);
				chk1("so", 1'b1, so);
			end
		join
		chk1("so_oe_b", 1'b1, so_oe_b);
		chk1("latch", 1'b1, status[1]);
		host.frame(`OP_LATCH_CLEAR, 7);
		chk1("latch", 1'b1, status[1]);
		host.frame(`OP_LATCH_CLEAR, 8);
		chk1("latch", 1'b0, status[1]);
		$display("link test done");
		// Busy refusal leaves state alone
		host.frame(`OP_LATCH_SET, 8);
		@(posedge clk);
		#2 busy = 1'b1;
		req(1'b0, 13'h0000, 8'h00, g, j);
		chk1("reject", 1'b1, j);
		chk8("status", 8'h0b, status);
		@(posedge clk);
		#2 busy = 1'b0;
		req(1'b0, 13'h0000, 8'h00, g, j);
		chk1("grant", 1'b1, g);
		pulse_done();
		chk8("status", 8'h08, status);
		$display("busy test done");
		// Reset in mid-run clears the latch
		host.frame(`OP_LATCH_SET, 8);
		@(posedge clk);
		#2 rst_b = 1'b0;
		repeat (3) @(posedge clk);
		#2 rst_b = 1'b1;
		repeat (2) @(posedge clk);
		#2;
		chk8("status", 8'h00, status);
		chk1("active", 1'b0, active);
		$display("second reset test done");
		end_of_test();
	end
endmodule // eeprom_write_guard_tb
